// *** core/rmc_monitor_config.sv ***
`include "rmc_defs.svh"

// Configuration bank for a set of resource monitors of one type, with a
// small per-instance event counter so that filters, enable, freeze and the
// wrap flag have something to act on.
module rmc_monitor_config #(
  parameter int unsigned        NUM_INST  = 4,
  parameter int unsigned        CNT_W     = 32,
  parameter int unsigned        INC_W     = 8,
  parameter logic [7:0]         MON_TYPE  = `RMC_TYPE_BANDWIDTH
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire rmc_pkg::rmc_idx_t  regIdx,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  input  wire rmc_pkg::rmc_word_t regWdata,
  output logic [31:0]           regRdata_q,
  output logic                  regRvalid_q,
  input  wire logic             evValid,
  input  wire rmc_pkg::rmc_part_t evPartition,
  input  wire rmc_pkg::rmc_grp_t  evGroup,
  input  wire logic [INC_W-1:0] evIncrement
);
  import rmc_pkg::*;

  localparam int unsigned SEL_W = (NUM_INST > 1) ? $clog2(NUM_INST) : 1;

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  logic [SEL_W-1:0] instSel_q;                // Selected instance.
  logic [SEL_W-1:0] instSel_d;                // Next selected instance.
  rmc_part_t        fltPart_q  [NUM_INST];    // Partition match values.
  rmc_part_t        fltPart_d  [NUM_INST];    // Next partition values.
  rmc_grp_t         fltGrp_q   [NUM_INST];    // Group match values.
  rmc_grp_t         fltGrp_d   [NUM_INST];    // Next group values.
  logic             partEn_q   [NUM_INST];    // Partition filter enables.
  logic             partEn_d   [NUM_INST];    // Next partition enables.
  logic             grpEn_q    [NUM_INST];    // Group filter enables.
  logic             grpEn_d    [NUM_INST];    // Next group enables.
  logic             freeze_q   [NUM_INST];    // Freeze-on-wrap selections.
  logic             freeze_d   [NUM_INST];    // Next freeze selections.
  logic             wrapFlag_q [NUM_INST];    // Sticky wrap flags.
  logic             wrapFlag_d [NUM_INST];    // Next wrap flags.
  logic             enable_q   [NUM_INST];    // Monitor enables.
  logic             enable_d   [NUM_INST];    // Next monitor enables.
  logic [CNT_W-1:0] count_q    [NUM_INST];    // Event counts.
  logic [CNT_W-1:0] count_d    [NUM_INST];    // Next event counts.
  logic [31:0]      regRdata_d;               // Next read data.
  logic             regRvalid_d;              // Next read strobe.
  logic             selValid;                 // Selector names a real instance.

  // The selector may be written with a value past the last instance.
  assign selValid = (32'(instSel_q) < NUM_INST);

  // ---------------------------------------------------------------
  // Per-instance configuration and counting.
  // ---------------------------------------------------------------

  // Applies writes first and then overlays the counting effect of an event.
  always_comb
  begin
    instSel_d = instSel_q;
    if (regWrite && (regIdx == `RMC_IDX_SELECT))
    begin
      instSel_d = regWdata[SEL_W-1:0];
    end
    for (int i = 0; i < NUM_INST; i++)
    begin
      logic          hit;
      logic          frozen;
      logic [CNT_W:0] sum;
      logic          wrSel;
      hit        = 1'b0;
      frozen     = 1'b0;
      sum        = '0;
      wrSel      = 1'b0;
      fltPart_d[i]  = fltPart_q[i];
      fltGrp_d[i]   = fltGrp_q[i];
      partEn_d[i]   = partEn_q[i];
      grpEn_d[i]    = grpEn_q[i];
      freeze_d[i]   = freeze_q[i];
      wrapFlag_d[i] = wrapFlag_q[i];
      enable_d[i]   = enable_q[i];
      count_d[i]    = count_q[i];
      // Only the selected copy sees a write.
      wrSel = regWrite && selValid && (32'(instSel_q) == i);
      // Match on the partition and group as carried by the request.
      hit = evValid && enable_q[i] &&
            rmc_match(partEn_q[i], grpEn_q[i], fltPart_q[i], fltGrp_q[i],
                      evPartition, evGroup);
      // A frozen counter holds the value left after it wrapped.
      frozen = freeze_q[i] && wrapFlag_q[i];
      sum    = {1'b0, count_q[i]} + (CNT_W+1)'(evIncrement);
      if (wrSel && (regIdx == `RMC_IDX_FILTER))
      begin
        fltPart_d[i] = regWdata[`RMC_FLT_PART_MSB:`RMC_FLT_PART_LSB];
        fltGrp_d[i]  = regWdata[`RMC_FLT_GRP_MSB:`RMC_FLT_GRP_LSB];
      end
      if (wrSel && (regIdx == `RMC_IDX_CONTROL))
      begin
        partEn_d[i] = regWdata[`RMC_CTL_PART_EN];
        grpEn_d[i]  = regWdata[`RMC_CTL_GRP_EN];
        freeze_d[i] = regWdata[`RMC_CTL_FREEZE];
        enable_d[i] = regWdata[`RMC_CTL_ENABLE];
        // Writing 0 clears the flag; writing 1 leaves it alone.
        if (!regWdata[`RMC_CTL_WRAP])
        begin
          wrapFlag_d[i] = 1'b0;
        end
      end
      if (hit && !frozen)
      begin
        // The count wraps and keeps its low bits.
        count_d[i] = sum[CNT_W-1:0];
        if (sum[CNT_W])
        begin
          // A wrap sets the flag even when a clear lands this cycle.
          wrapFlag_d[i] = 1'b1;
        end
      end
    end
  end

  // Registers the per-instance state.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      instSel_q <= '0;
      for (int i = 0; i < NUM_INST; i++)
      begin
        fltPart_q[i]  <= `RMC_RST_PART;
        fltGrp_q[i]   <= `RMC_RST_GRP;
        partEn_q[i]   <= 1'b0;
        grpEn_q[i]    <= 1'b0;
        freeze_q[i]   <= 1'b0;
        wrapFlag_q[i] <= 1'b0;
        enable_q[i]   <= 1'b0;
        count_q[i]    <= '0;
      end
    end
    else
    begin
      instSel_q <= instSel_d;
      for (int i = 0; i < NUM_INST; i++)
      begin
        fltPart_q[i]  <= fltPart_d[i];
        fltGrp_q[i]   <= fltGrp_d[i];
        partEn_q[i]   <= partEn_d[i];
        grpEn_q[i]    <= grpEn_d[i];
        freeze_q[i]   <= freeze_d[i];
        wrapFlag_q[i] <= wrapFlag_d[i];
        enable_q[i]   <= enable_d[i];
        count_q[i]    <= count_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path.
  // ---------------------------------------------------------------

  // Builds the read word of the selected copy; unused bits read zero.
  always_comb
  begin
    regRdata_d  = `RMC_RST_WORD;
    regRvalid_d = regRead;
    if (regRead)
    begin
      unique case (regIdx)
        `RMC_IDX_SELECT:
        begin
          regRdata_d[SEL_W-1:0] = instSel_q;
        end
        `RMC_IDX_TYPE_ID:
        begin
          // Number of instances of this monitor type.
          regRdata_d = 32'(NUM_INST);
        end
        `RMC_IDX_FILTER:
        begin
          // Bits 31:24 stay zero.
          if (selValid)
          begin
            regRdata_d[`RMC_FLT_PART_MSB:`RMC_FLT_PART_LSB] = fltPart_q[instSel_q];
            regRdata_d[`RMC_FLT_GRP_MSB:`RMC_FLT_GRP_LSB]   = fltGrp_q[instSel_q];
          end
        end
        `RMC_IDX_CONTROL:
        begin
          // Type code is constant; 15:8, 19:18 and others read zero.
          regRdata_d[`RMC_CTL_TYPE_MSB:0] = MON_TYPE;
          if (selValid)
          begin
            regRdata_d[`RMC_CTL_PART_EN] = partEn_q[instSel_q];
            regRdata_d[`RMC_CTL_GRP_EN]  = grpEn_q[instSel_q];
            regRdata_d[`RMC_CTL_FREEZE]  = freeze_q[instSel_q];
            regRdata_d[`RMC_CTL_WRAP]    = wrapFlag_q[instSel_q];
            regRdata_d[`RMC_CTL_ENABLE]  = enable_q[instSel_q];
          end
        end
        `RMC_IDX_COUNT:
        begin
          if (selValid)
          begin
            regRdata_d = 32'(count_q[instSel_q]);
          end
        end
        default:
        begin
          regRdata_d = `RMC_RST_WORD;
        end
      endcase
    end
  end

  // Registers the read answer.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      regRdata_q  <= `RMC_RST_WORD;
      regRvalid_q <= 1'b0;
    end
    else
    begin
      regRdata_q  <= regRdata_d;
      regRvalid_q <= regRvalid_d;
    end
  end

endmodule

// *** core/rmc_defs.svh ***
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH

// ---------------------------------------------------------------
// Register indices on the register port.
// ---------------------------------------------------------------
`define RMC_IDX_SELECT   3'h0
`define RMC_IDX_FILTER   3'h1
`define RMC_IDX_CONTROL  3'h2
`define RMC_IDX_TYPE_ID  3'h3
`define RMC_IDX_COUNT    3'h4

// ---------------------------------------------------------------
// Field positions of the filter and control registers.
// ---------------------------------------------------------------
`define RMC_FLT_PART_LSB 0
`define RMC_FLT_PART_MSB 15
`define RMC_FLT_GRP_LSB  16
`define RMC_FLT_GRP_MSB  23
`define RMC_CTL_TYPE_MSB 7
`define RMC_CTL_PART_EN  16
`define RMC_CTL_GRP_EN   17
`define RMC_CTL_FREEZE   24
`define RMC_CTL_WRAP     26
`define RMC_CTL_ENABLE   31

// ---------------------------------------------------------------
// Reset values and assigned type codes.
// ---------------------------------------------------------------
`define RMC_TYPE_BANDWIDTH 8'h42
`define RMC_TYPE_CACHE     8'h43
`define RMC_RST_PART       16'h0000
`define RMC_RST_GRP        8'h00
`define RMC_RST_WORD       32'h0000_0000

`endif

// *** core/rmc_pkg.sv ***
package rmc_pkg;

  // Register index carried on the register port.
  typedef logic [2:0]  rmc_idx_t;
  // One 32-bit register word.
  typedef logic [31:0] rmc_word_t;
  // Request partition identifier as carried on the request.
  typedef logic [15:0] rmc_part_t;
  // Request monitor group.
  typedef logic [7:0]  rmc_grp_t;

  // Returns true when an event passes the enabled filters of one instance.
  function automatic logic rmc_match(input logic      partEn,
                                     input logic      grpEn,
                                     input rmc_part_t fltPart,
                                     input rmc_grp_t  fltGrp,
                                     input rmc_part_t evPart,
                                     input rmc_grp_t  evGrp);
    logic partOk;
    logic grpOk;
    partOk = !partEn || (fltPart == evPart);
    grpOk  = !grpEn || (fltGrp == evGrp);
    return partOk && grpOk;
  endfunction

endpackage

// *** tb/rmc_monitor_config_props.sv ***
`include "rmc_defs.svh"

// ------------------------------------------------------------
// Read-side checks of the monitor configuration bank.
// ------------------------------------------------------------
module rmc_monitor_config_props
  import rmc_pkg::*;
#(
  parameter int unsigned NUM_INST = 4,
  parameter logic [7:0]  MON_TYPE = 8'h42
) (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire rmc_pkg::rmc_idx_t  regIdx,
  input wire logic               regRead,
  input wire logic [31:0]        regRdata_q,
  input wire logic               regRvalid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // A read strobe is answered exactly one cycle later, and only then.
  a_rvalid_after_read: assert property (regRead |=> regRvalid_q) else $error("read not answered");
  a_no_spurious_valid: assert property (!regRead |=> !regRvalid_q) else $error("valid without read");
  a_idle_data_zero: assert property (!regRead |=> regRdata_q == 32'h0) else $error("data not zero");
  // Field layout of the filter and control words.
  a_filter_top_zero: assert property (
    regRead && regIdx == `RMC_IDX_FILTER |=> regRdata_q[31:24] == 8'h00)
    else $error("filter top byte set");
  a_ctl_type_code: assert property (
    regRead && regIdx == `RMC_IDX_CONTROL |=> regRdata_q[7:0] == MON_TYPE)
    else $error("type code wrong");
  // Bits 30:27, 25, 23:18 and 15:8 of the control word always read zero.
  a_ctl_reserved_zero: assert property (
    regRead && regIdx == `RMC_IDX_CONTROL |=> (regRdata_q & 32'h7afc_ff00) == 32'h0)
    else $error("reserved bit set");
  // Instance count and unmapped places.
  a_inst_count: assert property (
    regRead && regIdx == `RMC_IDX_TYPE_ID |=> regRdata_q == NUM_INST)
    else $error("instance count wrong");
  a_unmapped_zero: assert property (
    regRead && regIdx > `RMC_IDX_COUNT |=> regRdata_q == 32'h0)
    else $error("unmapped read not zero");
endmodule

// *** tb/tb_top.sv ***
`include "rmc_defs.svh"

// ------------------------------------------------------------
// Directed bench for the monitor configuration bank.
// ------------------------------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rmc_pkg::*;
  logic clk_sys, resetn, regWrite, regRead, regRvalid_q, evValid;
  rmc_idx_t  regIdx;
  rmc_word_t regWdata, regRdata_q, d;
  rmc_part_t evPartition;
  rmc_grp_t  evGroup;
  logic [7:0] evIncrement;
  int n_errors = 0;
  int samples_checked = 0;

  // The counter is narrowed to 8 bits so that a wrap is cheap to reach.
  rmc_monitor_config #(.NUM_INST(4), .CNT_W(8), .INC_W(8), .MON_TYPE(8'h42)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .regIdx(regIdx), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q),
    .regRvalid_q(regRvalid_q), .evValid(evValid), .evPartition(evPartition),
    .evGroup(evGroup), .evIncrement(evIncrement));

  // The 125 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input rmc_word_t seen, input rmc_word_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One register write, held for exactly one taking edge.
  task automatic wr(input rmc_idx_t idx, input rmc_word_t data);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regIdx   <= idx;
    regWdata <= data;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  // One register read; the answer stands right after the taking edge.
  task automatic rd(input rmc_idx_t idx, output rmc_word_t data);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regIdx  <= idx;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk("rvalid", {31'h0, regRvalid_q}, 32'h1);
    data = regRdata_q;
  endtask

  // Sends events on back-to-back edges.
  task automatic ev(input rmc_part_t p[], input rmc_grp_t g[], input logic [7:0] n[]);
    foreach (p[i])
    begin
      @(posedge clk_sys);
      evValid     <= 1'b1;
      evPartition <= p[i];
      evGroup     <= g[i];
      evIncrement <= n[i];
    end
    @(posedge clk_sys);
    evValid <= 1'b0;
  endtask

  // Reset values and masking of unused or read-only bits.
  task automatic t_fields();
    rd(`RMC_IDX_CONTROL, d);
    chk("ctl_rst", d, 32'h0000_0042);
    rd(`RMC_IDX_FILTER, d);
    chk("flt_rst", d, 32'h0);
    wr(`RMC_IDX_SELECT, 32'h1);
    rd(`RMC_IDX_SELECT, d);
    chk("select", d, 32'h1);
    wr(`RMC_IDX_FILTER, 32'hffff_ffff);
    rd(`RMC_IDX_FILTER, d);
    chk("flt_mask", d, 32'h00ff_ffff);
    wr(`RMC_IDX_CONTROL, 32'hffff_ffff);
    rd(`RMC_IDX_CONTROL, d);
    chk("ctl_mask", d, 32'h8103_0042);
    rd(3'h6, d);
    chk("unmapped", d, 32'h0);
    rd(`RMC_IDX_TYPE_ID, d);
    chk("inst_count", d, 32'h4);
    $display("test fields done");
  endtask

  // Per-instance filters against back-to-back events.
  task automatic t_filter();
    rmc_word_t flt[4] = '{32'h0012_0034, 32'h0012_0000, 32'h0012_0034, 32'h0};
    rmc_word_t ctl[4] = '{32'h8001_0000, 32'h8002_0000, 32'h8003_0000, 32'h0003_0000};
    rmc_word_t cnt[4] = '{32'h3, 32'h5, 32'h1, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      wr(`RMC_IDX_SELECT, i);
      wr(`RMC_IDX_FILTER, flt[i]);
      wr(`RMC_IDX_CONTROL, ctl[i]);
    end
    ev('{16'h0034, 16'h0034, 16'h1034}, '{8'h12, 8'h99, 8'h12}, '{8'h1, 8'h2, 8'h4});
    wr(`RMC_IDX_SELECT, 32'h2);
    rd(`RMC_IDX_FILTER, d);
    chk("flt_inst2", d, flt[2]);
    for (int i = 0; i < 4; i++)
    begin
      wr(`RMC_IDX_SELECT, i);
      rd(`RMC_IDX_COUNT, d);
      chk("count", d, cnt[i]);
    end
    $display("test filter done");
  endtask

  // Wrap, freeze at the post-wrap value, clearing the flag.
  task automatic t_wrap();
    wr(`RMC_IDX_SELECT, 32'h0);
    wr(`RMC_IDX_CONTROL, 32'h8101_0000);
    ev('{16'h0034, 16'h0034}, '{8'h55, 8'h55}, '{8'hff, 8'h5});
    rd(`RMC_IDX_COUNT, d);
    chk("frozen", d, 32'h2);
    rd(`RMC_IDX_CONTROL, d);
    chk("wrap_set", d, 32'h8501_0042);
    wr(`RMC_IDX_CONTROL, 32'h8101_0000);
    rd(`RMC_IDX_CONTROL, d);
    chk("wrap_clr", d, 32'h8101_0042);
    ev('{16'h0034}, '{8'h55}, '{8'h5});
    rd(`RMC_IDX_COUNT, d);
    chk("resumed", d, 32'h7);
    // Without freeze the count wraps and goes on counting.
    wr(`RMC_IDX_CONTROL, 32'h8001_0000);
    ev('{16'h0034, 16'h0034}, '{8'h55, 8'h55}, '{8'hff, 8'h5});
    rd(`RMC_IDX_COUNT, d);
    chk("wrapped", d, 32'hb);
    rd(`RMC_IDX_CONTROL, d);
    chk("wrap_free", d, 32'h8401_0042);
    // A wrap in the cycle of a clearing write keeps the flag set.
    fork
      wr(`RMC_IDX_CONTROL, 32'h8001_0000);
      ev('{16'h0034}, '{8'h55}, '{8'hff});
    join
    rd(`RMC_IDX_CONTROL, d);
    chk("set_wins", d, 32'h8401_0042);
    rd(`RMC_IDX_COUNT, d);
    chk("rewrapped", d, 32'ha);
    $display("test wrap done");
  endtask

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    {resetn, regWrite, regRead, evValid} = 4'h0;
    regIdx = 3'h0;
    regWdata = 32'h0;
    evPartition = 16'h0;
    evGroup = 8'h0;
    evIncrement = 8'h0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_fields();
    t_filter();
    t_wrap();
    test_done();
  end
endmodule

bind rmc_monitor_config rmc_monitor_config_props #(.NUM_INST(NUM_INST), .MON_TYPE(MON_TYPE))
  u_props (.clk_sys(clk_sys), .resetn(resetn), .regIdx(regIdx), .regRead(regRead),
           .regRdata_q(regRdata_q), .regRvalid_q(regRvalid_q));
